// >>> common/bafe_defs.vh
// register map, field positions and reset values of the front-end control registers
`ifndef BAFE_DEFS_VH
`define BAFE_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define BAFE_ADDR_SCRATCH 7'h00
`define BAFE_ADDR_CELL_MONITOR_SELECT 7'h01
`define BAFE_ADDR_CURRENT_MONITOR_CONTROL 7'h02
`define BAFE_ADDR_GATE_DRIVER_CONTROL 7'h03
`define BAFE_ADDR_CHARGER_SENSE_CONTROL 7'h04

// ****************************************
// reset values
// ****************************************
`define BAFE_RST_SCRATCH 8'h00
`define BAFE_RST_CELL_MONITOR_SELECT 8'h00
`define BAFE_RST_CURRENT_MONITOR_CONTROL 8'h00
`define BAFE_RST_GATE_DRIVER_CONTROL 8'h00
`define BAFE_RST_CHARGER_SENSE_CONTROL 8'h00

// ****************************************
// field positions
// ****************************************
`define BAFE_CELL_SEL_LSB 0
`define BAFE_CELL_SEL_MSB 3
`define BAFE_CELL_OUT_EN 4
`define BAFE_AMP_GAIN 0
`define BAFE_AMP_ZERO 1
`define BAFE_GCAL_IN 2
`define BAFE_GCAL_OUT 3
`define BAFE_AMP_OUT_EN 4
`define BAFE_GATE_DIS 0
`define BAFE_GATE_CHG 1
`define BAFE_GATE_BOOST 4
`define BAFE_LOW_STATE 0
`define BAFE_LOW_FLAG 1
`define BAFE_LOW_IRQ_EN 2
`define BAFE_LOW_EN 3
`define BAFE_HIGH_STATE 4
`define BAFE_HIGH_FLAG 5
`define BAFE_HIGH_IRQ_EN 6
`define BAFE_HIGH_EN 7

// writable masks; other bits read as zero
`define BAFE_MASK_CELL 8'h1f
`define BAFE_MASK_CURRENT 8'h1f
`define BAFE_MASK_GATE 8'h13

// ****************************************
// serial frame
// ****************************************
`define BAFE_FRAME_BITS 16
`define BAFE_HDR_BITS 8
// sense-input positive routing codes
`define BAFE_POS_PIN 2'h0
`define BAFE_POS_GND 2'h1
`define BAFE_POS_REF_HI 2'h2
`define BAFE_POS_REF_LO 2'h3

`endif

// >>> verilog/bafe_regs.v
// control registers of the battery front end behind a mode-0 serial port
//
// Functional notes
// R1 - cell output zero unless enabled
// R2 - cell code zero is lowest cell
// R3 - gain bit: ten when 0, fifty when 1
// R4 - zero correction grounds both sense inputs
// R5 - zero correction overrides both calibration bits
// R6 - calibration grounds negative, positive to reference
// R7 - both calibration bits route reference to output
// R8 - current output zero unless enabled
// R9 - short detection ignores current monitor settings
// R10 - discharge bit drives discharge gate
// R11 - short clears discharge bit, no auto-restore
// R12 - charge bit drives or floats charge gate
// R13 - master rewrites gate bits after short
// R14 - boost bit selects enhanced gate current
// R15 - master clears boost after gates risen
// R16 - frame flag: 0 writes, 1 reads
// R17 - short trip flags and clears both gate bits
// R18 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "bafe_defs.vh"

module bafe_regs (
    ref_clk,
    rst_n,
    spi_cs_n,
    spi_sck,
    spi_sdi,
    spi_sdo,
    short_detect,
    low_cmp_in,
    high_cmp_in,
    cell_voltage_output_en,
    cell_select,
    amp_gain_select,
    sense_input_pos_sel,
    sense_input_neg_gnd,
    current_sense_output_en,
    current_sense_output_ref,
    discharge_gate_pin,
    charge_gate_pin_out,
    charge_gate_pin_oe_n,
    gate_drive_boost,
    short_trip,
    low_cmp_enable,
    high_cmp_enable
);
    input wire ref_clk;
    input wire rst_n;
    input wire spi_cs_n;
    input wire spi_sck;
    input wire spi_sdi;
    output reg spi_sdo;
    input wire short_detect;
    input wire low_cmp_in;
    input wire high_cmp_in;
    output wire cell_voltage_output_en;
    output wire [3:0] cell_select;
    output wire amp_gain_select;
    output reg [1:0] sense_input_pos_sel;
    output wire sense_input_neg_gnd;
    output wire current_sense_output_en;
    output wire current_sense_output_ref;
    output wire discharge_gate_pin;
    output wire charge_gate_pin_out;
    output wire charge_gate_pin_oe_n;
    output wire gate_drive_boost;
    output reg short_trip;
    output wire low_cmp_enable;
    output wire high_cmp_enable;

    // ****************************************
    // input synchronisers
    // ****************************************
    reg [5:0] sync1;
    reg [5:0] sync2;
    reg sck_d;
    reg short_d;
    wire cs_n_s = sync2[0];
    wire sck_s = sync2[1];
    wire sdi_s = sync2[2];
    wire short_s = sync2[3];
    wire low_s = sync2[4];
    wire high_s = sync2[5];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // only cs idles high; a 1 on the short path would fake a trip
            sync1 <= 6'h01;
            sync2 <= 6'h01;
            sck_d <= 1'b0;
            short_d <= 1'b0;
        end else begin
            sync1 <= {high_cmp_in, low_cmp_in, short_detect, spi_sdi, spi_sck, spi_cs_n};
            sync2 <= sync1;
            sck_d <= sck_s;
            short_d <= short_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_d & ~cs_n_s;
    // the short comparator path reads none of the current monitor bits
    // R9 independent short path
    wire short_edge = short_s & ~short_d;

    // ****************************************
    // serial frame: 7-bit address, read flag, 8 data bits, msb first
    // ****************************************
    reg [4:0] bit_cnt;
    reg [14:0] rx_sr;
    reg [7:0] tx_sr;
    reg [7:0] scratch;
    reg [7:0] cell_reg;
    reg [7:0] cur_reg;
    reg [7:0] gate_reg;
    reg [3:0] chg_ctl;
    reg low_flag;
    reg high_flag;
    reg low_prev;
    reg high_prev;

    wire [7:0] chg_view = {chg_ctl[3], chg_ctl[2], high_flag, high_s & chg_ctl[3],
                           chg_ctl[1], chg_ctl[0], low_flag, low_s & chg_ctl[1]};
    wire hdr_done = sck_rise && (bit_cnt == (`BAFE_HDR_BITS - 1));
    wire frame_done = sck_rise && (bit_cnt == (`BAFE_FRAME_BITS - 1));
    wire [6:0] hdr_addr = rx_sr[6:0];
    wire [6:0] wr_addr = rx_sr[14:8];
    // R16 flag 0 means write
    wire wr_go = frame_done && !rx_sr[7];
    wire [7:0] wr_data = {rx_sr[6:0], sdi_s};

    function [7:0] rd_mux;
        input [6:0] a;
        input [7:0] s, c, i, g, p;
        begin
            case (a)
                `BAFE_ADDR_SCRATCH: rd_mux = s;
                `BAFE_ADDR_CELL_MONITOR_SELECT: rd_mux = c;
                `BAFE_ADDR_CURRENT_MONITOR_CONTROL: rd_mux = i;
                `BAFE_ADDR_GATE_DRIVER_CONTROL: rd_mux = g;
                `BAFE_ADDR_CHARGER_SENSE_CONTROL: rd_mux = p;
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    wire [7:0] rd_word = rd_mux(hdr_addr, scratch, cell_reg, cur_reg, gate_reg, chg_view);

    function is_wr;
        input go;
        input [6:0] a;
        input [6:0] target;
        begin
            is_wr = go && (a == target);
        end
    endfunction

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            rx_sr <= 15'h0000;
            tx_sr <= 8'h00;
            spi_sdo <= 1'b0;
        end else if (cs_n_s) begin
            bit_cnt <= 5'h00;
            spi_sdo <= 1'b0;
        end else begin
            if (sck_rise) begin
                rx_sr <= {rx_sr[13:0], sdi_s};
                bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
            end
            // R16 flag 1 means read
            if (hdr_done && sdi_s) begin
                tx_sr <= rd_word;
                spi_sdo <= rd_word[7];
            end else if (hdr_done) begin
                tx_sr <= 8'h00;
                spi_sdo <= 1'b0;
            end else if (sck_fall && bit_cnt > `BAFE_HDR_BITS) begin
                // shift on falling edge so the master samples on the rising one
                tx_sr <= {tx_sr[6:0], 1'b0};
                spi_sdo <= tx_sr[6];
            end
        end
    end

    // ****************************************
    // register bank
    // ****************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch <= `BAFE_RST_SCRATCH;
            cell_reg <= `BAFE_RST_CELL_MONITOR_SELECT;
            cur_reg <= `BAFE_RST_CURRENT_MONITOR_CONTROL;
            gate_reg <= `BAFE_RST_GATE_DRIVER_CONTROL;
            chg_ctl <= 4'h0;
            low_flag <= 1'b0;
            high_flag <= 1'b0;
            short_trip <= 1'b0;
        end else begin
            short_trip <= short_edge;
            if (is_wr(wr_go, wr_addr, `BAFE_ADDR_SCRATCH))
                scratch <= wr_data;
            // R18 reserved bits masked
            if (is_wr(wr_go, wr_addr, `BAFE_ADDR_CELL_MONITOR_SELECT))
                cell_reg <= wr_data & `BAFE_MASK_CELL;
            if (is_wr(wr_go, wr_addr, `BAFE_ADDR_CURRENT_MONITOR_CONTROL))
                cur_reg <= wr_data & `BAFE_MASK_CURRENT;
            // R17 short wins over write
            if (short_edge) begin
                // R11 clear discharge bit
                gate_reg[`BAFE_GATE_DIS] <= 1'b0;
                // R17 clear charge bit
                gate_reg[`BAFE_GATE_CHG] <= 1'b0;
                // R13 no hardware restore
                if (is_wr(wr_go, wr_addr, `BAFE_ADDR_GATE_DRIVER_CONTROL))
                    gate_reg[`BAFE_GATE_BOOST] <= wr_data[`BAFE_GATE_BOOST];
            end else if (is_wr(wr_go, wr_addr, `BAFE_ADDR_GATE_DRIVER_CONTROL)) begin
                gate_reg <= wr_data & `BAFE_MASK_GATE;
            end
            if (is_wr(wr_go, wr_addr, `BAFE_ADDR_CHARGER_SENSE_CONTROL))
                chg_ctl <= {wr_data[`BAFE_HIGH_EN], wr_data[`BAFE_HIGH_IRQ_EN],
                            wr_data[`BAFE_LOW_EN], wr_data[`BAFE_LOW_IRQ_EN]};
            // flags: rising comparator state sets, writing 0 clears, set wins
            if (!chg_ctl[0])
                low_flag <= 1'b0;
            else if (low_s & chg_ctl[1] & ~low_prev)
                low_flag <= 1'b1;
            else if (is_wr(wr_go, wr_addr, `BAFE_ADDR_CHARGER_SENSE_CONTROL)
                     && !wr_data[`BAFE_LOW_FLAG])
                low_flag <= 1'b0;
            if (!chg_ctl[2])
                high_flag <= 1'b0;
            else if (high_s & chg_ctl[3] & ~high_prev)
                high_flag <= 1'b1;
            else if (is_wr(wr_go, wr_addr, `BAFE_ADDR_CHARGER_SENSE_CONTROL)
                     && !wr_data[`BAFE_HIGH_FLAG])
                high_flag <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_prev <= 1'b0;
            high_prev <= 1'b0;
        end else begin
            low_prev <= low_s & chg_ctl[1];
            high_prev <= high_s & chg_ctl[3];
        end
    end

    // ****************************************
    // analog steering
    // ****************************************
    // R1 cell output enable
    assign cell_voltage_output_en = cell_reg[`BAFE_CELL_OUT_EN];
    // R2 code 0 is lowest cell
    assign cell_select = cell_reg[`BAFE_CELL_SEL_MSB:`BAFE_CELL_SEL_LSB];
    // R3 gain ten or fifty
    assign amp_gain_select = cur_reg[`BAFE_AMP_GAIN];

    wire zero_on = cur_reg[`BAFE_AMP_ZERO];
    // R5 zero overrides calibration
    wire cal_in = cur_reg[`BAFE_GCAL_IN] & ~zero_on;
    wire cal_out = cur_reg[`BAFE_GCAL_OUT] & ~zero_on;

    always @* begin
        // R4 zero grounds inputs
        if (zero_on)
            sense_input_pos_sel = `BAFE_POS_GND;
        // R6 reference by gain
        else if (cal_in)
            sense_input_pos_sel = amp_gain_select ? `BAFE_POS_REF_LO : `BAFE_POS_REF_HI;
        else
            sense_input_pos_sel = `BAFE_POS_PIN;
    end

    // R6 negative grounded
    assign sense_input_neg_gnd = zero_on | cal_in;
    // R7 reference to output
    assign current_sense_output_ref = cal_in & cal_out;
    // R8 output enable
    assign current_sense_output_en = cur_reg[`BAFE_AMP_OUT_EN];

    // R10 discharge gate drive
    assign discharge_gate_pin = gate_reg[`BAFE_GATE_DIS];
    // R12 charge gate high or floating
    assign charge_gate_pin_out = gate_reg[`BAFE_GATE_CHG];
    assign charge_gate_pin_oe_n = ~gate_reg[`BAFE_GATE_CHG];
    // R14 enhanced drive current
    assign gate_drive_boost = gate_reg[`BAFE_GATE_BOOST];
    // R15 software limits boost time
    assign low_cmp_enable = chg_ctl[1];
    assign high_cmp_enable = chg_ctl[3];

endmodule // bafe_regs

// >>> sim/bafe_props.sv
// concurrent checks on the front-end control register block
`timescale 1ns/1ps
`include "bafe_defs.vh"

module bafe_props (
    input wire ref_clk,
    input wire rst_n,
    input wire spi_cs_n,
    input wire spi_sdo,
    input wire short_detect,
    input wire [3:0] cell_select,
    input wire cell_voltage_output_en,
    input wire amp_gain_select,
    input wire [1:0] sense_input_pos_sel,
    input wire sense_input_neg_gnd,
    input wire current_sense_output_ref,
    input wire discharge_gate_pin,
    input wire charge_gate_pin_out,
    input wire charge_gate_pin_oe_n,
    input wire gate_drive_boost,
    input wire short_trip
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_trip_edge; $rose(short_detect); endsequence
    // long idle so the cs synchronizer has settled
    sequence s_cs_idle; spi_cs_n [*8]; endsequence
    property p_trip; s_trip_edge |-> ##[1:5] short_trip; endproperty
    a_trip: assert property (p_trip) else $error("short trip missing");
    property p_pulse; short_trip |=> !short_trip; endproperty
    a_pulse: assert property (p_pulse) else $error("short trip too long");
    property p_clear; short_trip |-> ##[0:1] (!discharge_gate_pin && charge_gate_pin_oe_n); endproperty
    a_clear: assert property (p_clear) else $error("gates still on after trip");
    property p_chg; charge_gate_pin_oe_n == !charge_gate_pin_out; endproperty
    a_chg: assert property (p_chg) else $error("charge gate enable mismatch");
    property p_zero; (sense_input_pos_sel == `BAFE_POS_GND) |->
        (sense_input_neg_gnd && !current_sense_output_ref); endproperty
    a_zero: assert property (p_zero) else $error("zero routing wrong");
    property p_cal; sense_input_pos_sel[1] |->
        (sense_input_neg_gnd && sense_input_pos_sel[0] == amp_gain_select); endproperty
    a_cal: assert property (p_cal) else $error("calibration reference wrong");
    property p_ref; current_sense_output_ref |-> sense_input_pos_sel[1]; endproperty
    a_ref: assert property (p_ref) else $error("reference output without input switch");
    property p_neg; sense_input_neg_gnd |-> (sense_input_pos_sel != `BAFE_POS_PIN); endproperty
    a_neg: assert property (p_neg) else $error("negative grounded alone");
    property p_hold; s_cs_idle |-> ($stable(cell_select) && $stable(cell_voltage_output_en)
        && $stable(amp_gain_select) && $stable(gate_drive_boost)); endproperty
    a_hold: assert property (p_hold) else $error("register moved while idle");
    property p_sdo; s_cs_idle |-> !spi_sdo; endproperty
    a_sdo: assert property (p_sdo) else $error("data out active while idle");
endmodule // bafe_props

bind bafe_regs bafe_props i_props (.ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sdo(spi_sdo), .short_detect(short_detect), .cell_select(cell_select),
    .cell_voltage_output_en(cell_voltage_output_en), .amp_gain_select(amp_gain_select),
    .sense_input_pos_sel(sense_input_pos_sel), .sense_input_neg_gnd(sense_input_neg_gnd),
    .current_sense_output_ref(current_sense_output_ref), .short_trip(short_trip),
    .discharge_gate_pin(discharge_gate_pin), .charge_gate_pin_out(charge_gate_pin_out),
    .charge_gate_pin_oe_n(charge_gate_pin_oe_n), .gate_drive_boost(gate_drive_boost));

// >>> sim/bafe_spi_master.sv
// serial master model of the external controller
`timescale 1ns/1ps

module bafe_spi_master (
    input wire ref_clk,
    output reg spi_cs_n,
    output reg spi_sck,
    output reg spi_sdi,
    input wire spi_sdo
);
    // ****************************************
    // frame transfer
    // ****************************************
    // 504 ns keeps every phase above the 500 ns minimum
    localparam integer HALF = 63;
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end
    task xfer(input [6:0] adr, input rd, input [7:0] wd, output [7:0] rdat);
        reg [15:0] f;
        integer i;
        begin
            f = {adr, rd, wd};
            rdat = 8'h00;
            @(negedge ref_clk);
            spi_cs_n = 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                spi_sdi = f[i];
                repeat (HALF) @(negedge ref_clk);
                spi_sck = 1'b1;
                if (i < 8) rdat = {rdat[6:0], spi_sdo};
                repeat (HALF) @(negedge ref_clk);
                spi_sck = 1'b0;
            end
            repeat (HALF) @(negedge ref_clk);
            spi_cs_n = 1'b1;
            // released line must not keep the last bit
            spi_sdi = ~spi_sdi;
            repeat (HALF) @(negedge ref_clk);
        end
    endtask
endmodule // bafe_spi_master

// >>> sim/tb_top.sv
// self-checking bench for the front-end control registers
`timescale 1ns/1ps

module tb_top;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg short_detect = 1'b0;
    reg low_cmp_in = 1'b0;
    reg high_cmp_in = 1'b0;
    wire spi_cs_n, spi_sck, spi_sdi, spi_sdo, cell_voltage_output_en, amp_gain_select;
    wire sense_input_neg_gnd, current_sense_output_en, current_sense_output_ref;
    wire discharge_gate_pin, charge_gate_pin_out, charge_gate_pin_oe_n, gate_drive_boost;
    wire short_trip, low_cmp_enable, high_cmp_enable;
    wire [3:0] cell_select;
    wire [1:0] sense_input_pos_sel;
    wire [7:0] cv = {3'b000, cell_voltage_output_en, cell_select};
    wire [7:0] iv = {2'b00, current_sense_output_en, amp_gain_select, sense_input_pos_sel,
        sense_input_neg_gnd, current_sense_output_ref};
    wire [7:0] gv = {4'h0, discharge_gate_pin, charge_gate_pin_out, charge_gate_pin_oe_n,
        gate_drive_boost};
    // written values and expected {en, gain, pos, neg, ref}
    localparam [71:0] IW = 72'h10_11_13_1e_14_15_1c_18_0c;
    localparam [71:0] IE = 72'h20_30_36_26_2a_3e_2b_20_0b;
    integer errors = 0;
    integer checks = 0;
    integer i;
    reg [7:0] q;
    always #4 ref_clk = ~ref_clk;
    bafe_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .short_detect(short_detect),
        .low_cmp_in(low_cmp_in), .high_cmp_in(high_cmp_in), .cell_select(cell_select),
        .cell_voltage_output_en(cell_voltage_output_en), .amp_gain_select(amp_gain_select),
        .sense_input_pos_sel(sense_input_pos_sel), .sense_input_neg_gnd(sense_input_neg_gnd),
        .current_sense_output_en(current_sense_output_en), .short_trip(short_trip),
        .current_sense_output_ref(current_sense_output_ref),
        .discharge_gate_pin(discharge_gate_pin), .charge_gate_pin_out(charge_gate_pin_out),
        .charge_gate_pin_oe_n(charge_gate_pin_oe_n), .gate_drive_boost(gate_drive_boost),
        .low_cmp_enable(low_cmp_enable), .high_cmp_enable(high_cmp_enable));
    bafe_spi_master i_mst (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
    // ****************************************
    // tasks
    // ****************************************
    task report_and_stop;
        begin
            $display("errors %0d checks %0d", errors, checks);
            if (errors == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        begin
            i_mst.xfer(a, 1'b0, d, q);
        end
    endtask
    task rd(input [6:0] a, input [7:0] e);
        begin
            i_mst.xfer(a, 1'b1, 8'h00, q);
            chk("readback", e, q);
        end
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("gates", 8'h02, gv);
        for (i = 0; i < 5; i = i + 1) rd(i, 8'h00);
        wr(7'h00, 8'ha5);
        rd(7'h00, 8'ha5);
        wr(7'h05, 8'hff);
        rd(7'h05, 8'h00);
        wr(7'h01, 8'hff);
        rd(7'h01, 8'h1f);
        for (i = 0; i < 4; i = i + 1) begin
            wr(7'h01, 8'h10 | (i * 5));
            chk("cell", 8'h10 | (i * 5), cv);
        end
        wr(7'h01, 8'h0f);
        chk("cell", 8'h0f, cv);
        for (i = 0; i < 9; i = i + 1) begin
            wr(7'h02, IW[8 * (8 - i) +: 8]);
            chk("current", IE[8 * (8 - i) +: 8], iv);
        end
        wr(7'h03, 8'hff);
        chk("gates", 8'h0d, gv);
        rd(7'h03, 8'h13);
        short_detect = 1'b1;
        for (i = 0; i < 20 && short_trip !== 1'b1; i = i + 1) @(negedge ref_clk);
        chk("trip", 8'h01, {7'h00, short_trip});
        if (short_trip !== 1'b1) report_and_stop;
        repeat (2) @(negedge ref_clk);
        chk("gates", 8'h03, gv);
        short_detect = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("gates", 8'h03, gv);
        rd(7'h03, 8'h10);
        wr(7'h03, 8'h03);
        chk("gates", 8'h0c, gv);
        i_mst.xfer(7'h03, 1'b1, 8'hff, q);
        chk("gates", 8'h0c, gv);
        wr(7'h04, 8'hcc);
        chk("enables", 8'h03, {6'h00, high_cmp_enable, low_cmp_enable});
        low_cmp_in = 1'b1;
        repeat (8) @(negedge ref_clk);
        rd(7'h04, 8'hcf);
        high_cmp_in = 1'b1;
        repeat (8) @(negedge ref_clk);
        rd(7'h04, 8'hff);
        wr(7'h04, 8'hcc);
        rd(7'h04, 8'hdd);
        report_and_stop;
    end
endmodule // tb_top
